// File: src/clc_camera_light_controller.sv
// Camera trigger and strobe cycle controller with its register port.
//
// Summary of operation
// (R1) Each launch gives one camera pulse, one strobe pulse, one permit.
// (R2) Camera pulse width equals the programmed camera trigger width, one cycle if that is zero.
// (R3) Strobe width equals its own programmed width, one cycle if that is zero.
// (R4) Strobe rises the programmed offset after the camera pulse rises.
// (R5) Negative offset: strobe rises at launch, camera after the magnitude.
// (R6) Permit position is a programmed value, an earlier one with overlap.
// (R7) With overlap, camera pulses keep the minimum exposure gap.
// (R8) Launches are spaced at least the minimum cycle period apart.
// (R9) No launch unless the sequence is active.
// (R10) No launch before the previous cycle's permit.
// (R11) No launch while memory has no room.
// (R12) Triggered origin with limit zero: each launch needs a fresh trigger.
// (R13) Triggered origin with nonzero limit: launch serves a pending trigger first.
// (R14) Self-timed origin triggers at start, then each time the cycle gate is ready.
// (R15) Command or event origin waits for go command or event edge.
// (R16) Event sources: line, decoder, multiplier, divider, delay, input, user.
// (R17) Limit zero disables latching; one to seven gives that many entries.
// (R18) Software reads the pending trigger count.
// (R19) Rejected triggers in triggered origins bump the lost counter.
// (R20) An accepted trigger not served at once bumps the pending count.
// (R21) Trigger launches at once when active, the gate waits and no trigger is pending.
// (R22) Trigger latches when active, count below limit, and gate not ready or a trigger pending.
// (R23) Sequence controller governs trigger front end and cycle gate.
// (R24) Immediate begin origin starts from reset with no command or event; after an end it needs one.
// (R25) Length mode stops after the programmed cycle total, default one.
// (R26) Cycle total is captured when the sequence begins.
// (R27) A launch serving a latched trigger decrements the pending count.
// (R28) Pending count clears when the sequence ends or on reset.
`timescale 1ns/100ps
`include "clc_defines.svh"
module clc_camera_light_controller
	import clc_pkg::*;
#(
	parameter int TW = 24
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic [7:0] tool_events,
	input wire logic mem_room,
	output clc_out_t light
);
	clc_ctrl_t ctrl;
	logic [TW-1:0] cam_w, stb_w, stb_o, p_full, p_ovl, gap, min_p;
	logic [23:0] seq_t, seq_left, done;
	logic [31:0] lost_n;
	logic [2:0] pend;
	logic [7:0] ev_q, ev_rise;
	logic cmd_wr, go_cmd, beg_cmd, end_cmd;
	logic run;
	logic [TW:0] t, lc, ts, ss, te, se, tend;
	logic [TW-1:0] mag, cw_e, sw_e, pp, pc, gc;
	logic permit_hit, permit_ok, period_ok, gap_ok;
	clc_seq_t seq;
	logic seq_act, stop_req, start, beg_ev, end_ev, len_hit;
	logic self_m, trig_ev, ready, serve, imm, latch, lost, launch;

	// Register writes.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl <= clc_ctrl_t'(`CLC_R_CTRL);
			cam_w <= TW'(`CLC_R_CAMW);
			stb_w <= TW'(`CLC_R_STBW);
			stb_o <= TW'(`CLC_R_STBO);
			p_full <= TW'(`CLC_R_PFULL);
			p_ovl <= TW'(`CLC_R_POVL);
			gap <= TW'(`CLC_R_GAP);
			min_p <= TW'(`CLC_R_MINP);
			seq_t <= `CLC_R_SEQT;
		end else if (ce && wr) begin
			if (addr == `CLC_A_CTRL) begin
				ctrl <= clc_ctrl_t'(wdata[`CLC_CTRL_W-1:0]);
			end else if (addr == `CLC_A_CAMW) begin
				cam_w <= wdata[TW-1:0];
			end else if (addr == `CLC_A_STBW) begin
				stb_w <= wdata[TW-1:0];
			end else if (addr == `CLC_A_STBO) begin
				stb_o <= wdata[TW-1:0];
			end else if (addr == `CLC_A_PFULL) begin
				p_full <= wdata[TW-1:0];
			end else if (addr == `CLC_A_POVL) begin
				p_ovl <= wdata[TW-1:0];
			end else if (addr == `CLC_A_GAP) begin
				gap <= wdata[TW-1:0];
			end else if (addr == `CLC_A_MINP) begin
				min_p <= wdata[TW-1:0];
			end else if (addr == `CLC_A_SEQT) begin
				seq_t <= wdata[23:0];
			end
		end
	end

	// Register reads; data stand for one cycle only.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata <= '0;
		end else if (ce) begin
			rdata <= '0;
			if (rd) begin
				if (addr == `CLC_A_CTRL) begin
					rdata <= 32'(ctrl);
				end else if (addr == `CLC_A_CAMW) begin
					rdata <= 32'(cam_w);
				end else if (addr == `CLC_A_STBW) begin
					rdata <= 32'(stb_w);
				end else if (addr == `CLC_A_STBO) begin
					rdata <= 32'(stb_o);
				end else if (addr == `CLC_A_PFULL) begin
					rdata <= 32'(p_full);
				end else if (addr == `CLC_A_POVL) begin
					rdata <= 32'(p_ovl);
				end else if (addr == `CLC_A_GAP) begin
					rdata <= 32'(gap);
				end else if (addr == `CLC_A_MINP) begin
					rdata <= 32'(min_p);
				end else if (addr == `CLC_A_SEQT) begin
					rdata <= 32'(seq_t);
				end else if (addr == `CLC_A_STAT) begin
					rdata <= {25'h0, permit_ok, run, seq, pend}; // R18
				end else if (addr == `CLC_A_LOST) begin
					rdata <= lost_n;
				end else if (addr == `CLC_A_DONE) begin
					rdata <= 32'(done);
				end
			end
		end
	end

	// Command strobes and event edges.
	assign cmd_wr = ce && wr && addr == `CLC_A_CMD;
	assign go_cmd = cmd_wr && wdata[`CLC_B_GO];
	assign beg_cmd = cmd_wr && wdata[`CLC_B_BEG];
	assign end_cmd = cmd_wr && wdata[`CLC_B_END];

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ev_q <= '0;
		end else if (ce) begin
			ev_q <= tool_events;
		end
	end

	assign ev_rise = tool_events & ~ev_q;

	// Intra-cycle positions, measured from the first running cycle.
	always_comb begin
		mag = stb_o[TW-1] ? TW'(-stb_o) : stb_o;
		cw_e = (cam_w == '0) ? TW'(1) : cam_w;
		sw_e = (stb_w == '0) ? TW'(1) : stb_w;
		ts = stb_o[TW-1] ? {1'b0, mag} : '0; // R5
		ss = stb_o[TW-1] ? '0 : {1'b0, mag}; // R4
		te = ts + {1'b0, cw_e}; // R2
		se = ss + {1'b0, sw_e}; // R3
		pp = ctrl.overlap ? p_ovl : p_full; // R6
		tend = (te > se) ? te : se;
		if ({1'b0, pp} >= tend) begin
			tend = {1'b0, pp} + (TW+1)'(1);
		end
	end

	assign permit_hit = run && t == {1'b0, pp};

	// Timing engine run state.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			run <= 1'b0;
			t <= '0;
		end else if (ce) begin
			if (launch) begin
				run <= 1'b1;
				t <= '0;
			end else if (run) begin
				t <= t + 1'b1;
				if (t + 1'b1 >= tend) begin
					run <= 1'b0;
				end
			end
		end
	end

	// Registered outputs: one pulse of each kind per cycle.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			light <= '0;
		end else if (ce) begin
			light.cam <= run && t >= ts && t < te; // R1
			light.strobe <= run && t >= ss && t < se; // R1
			light.permit <= permit_hit; // R1
			light.launch <= launch;
		end
	end

	// Permit of the running cycle; a finished cycle always counts as permitted.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			permit_ok <= 1'b1;
		end else if (ce) begin
			if (launch) begin
				permit_ok <= 1'b0;
			end else if (permit_hit || !run) begin
				permit_ok <= 1'b1; // R10
			end
		end
	end

	// Cycles since the last launch and since the camera pulse fell.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pc <= '1;
		end else if (ce) begin
			if (launch) begin
				pc <= TW'(1);
			end else if (pc != '1) begin
				pc <= pc + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			gc <= '1;
		end else if (ce) begin
			if (light.cam) begin
				gc <= '0;
			end else if (gc != '1) begin
				gc <= gc + 1'b1;
			end
		end
	end

	assign period_ok = pc >= min_p; // R8
	assign gap_ok = !ctrl.overlap || gc >= gap; // R7

	// Cycle gate and trigger sorting.
	assign seq_act = seq == SEQ_ACTIVE;
	assign self_m = ctrl.orig == ORIG_SELF;
	assign trig_ev = !self_m && (go_cmd || (ctrl.orig == ORIG_EVENT && ev_rise[ctrl.tsel])); // R15 R16
	assign ready = seq_act && !stop_req && permit_ok && !run && period_ok && gap_ok && mem_room; // R9 R10 R11 R23
	assign serve = ready && !self_m && pend != 3'd0; // R13
	assign imm = ready && !self_m && pend == 3'd0 && trig_ev; // R12 R21
	assign latch = trig_ev && !imm && seq_act && pend < ctrl.limit; // R17 R20 R22
	assign lost = trig_ev && !imm && !latch; // R19
	assign launch = (ready && self_m) || serve || imm; // R14

	// Pending trigger count.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pend <= '0;
		end else if (ce) begin
			if (!seq_act) begin
				pend <= '0; // R28
			end else if (latch && !serve) begin
				pend <= pend + 3'd1; // R20
			end else if (serve && !latch) begin
				pend <= pend - 3'd1; // R27
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lost_n <= '0;
		end else if (ce && lost) begin
			lost_n <= lost_n + 32'd1; // R19
		end
	end

	// Sequence controller.
	assign beg_ev = beg_cmd || (ctrl.bsrc == BEG_EVENT && ev_rise[ctrl.bsel]);
	assign end_ev = end_cmd || (ctrl.esrc == END_EVENT && ev_rise[ctrl.esel]);
	assign start = (seq == SEQ_WAIT && ctrl.bsrc == BEG_IMM) || (!seq_act && beg_ev); // R24
	assign len_hit = ctrl.esrc == END_LEN && done + 24'd1 >= seq_left; // R25

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			seq <= SEQ_WAIT;
			seq_left <= '0;
			done <= '0;
			stop_req <= 1'b0;
		end else if (ce) begin
			case (seq)
				SEQ_WAIT, SEQ_ENDED: begin
					if (start) begin
						seq <= SEQ_ACTIVE;
						seq_left <= seq_t; // R26
						done <= '0;
						stop_req <= 1'b0;
					end
				end
				SEQ_ACTIVE: begin
					if (stop_req && !run) begin
						seq <= SEQ_ENDED; // R23
					end
					if (launch) begin
						done <= done + 24'd1;
					end
					if (end_ev || (launch && len_hit)) begin
						stop_req <= 1'b1; // R25
					end
				end
				default: begin
					seq <= SEQ_WAIT;
				end
			endcase
		end
	end

	// Checking helpers: cycles since launch and pulse lengths.
	logic [TW:0] hc;
	logic [TW:0] hs;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lc <= '0;
			hc <= '0;
			hs <= '0;
		end else if (ce) begin
			lc <= launch ? '0 : lc + 1'b1;
			hc <= light.cam ? hc + 1'b1 : '0;
			hs <= light.strobe ? hs + 1'b1 : '0;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	sequence s_launch;
		ce && launch;
	endsequence

	property p_cam_width;
		$fell(light.cam) |-> hc == {1'b0, cw_e};
	endproperty
	a_cam_width: assert property (p_cam_width) else $error("camera pulse width wrong"); // R2

	property p_stb_width;
		$fell(light.strobe) |-> hs == {1'b0, sw_e};
	endproperty
	a_stb_width: assert property (p_stb_width) else $error("strobe width wrong"); // R3

	property p_stb_rise;
		$rose(light.strobe) |-> lc == ss + 1'b1;
	endproperty
	a_stb_rise: assert property (p_stb_rise) else $error("strobe rise misplaced"); // R4

	property p_cam_rise;
		$rose(light.cam) |-> lc == ts + 1'b1;
	endproperty
	a_cam_rise: assert property (p_cam_rise) else $error("camera rise misplaced"); // R5

	property p_active;
		s_launch |-> seq == SEQ_ACTIVE ##1 run;
	endproperty
	a_active: assert property (p_active) else $error("launch outside active sequence"); // R9

	property p_permit;
		s_launch |-> permit_ok && pc >= min_p;
	endproperty
	a_permit: assert property (p_permit) else $error("launch before permit or period"); // R10

	property p_mem;
		s_launch |-> mem_room;
	endproperty
	a_mem: assert property (p_mem) else $error("launch without memory room"); // R11

	property p_lost;
		ce && lost |=> lost_n == $past(lost_n) + 32'd1;
	endproperty
	a_lost: assert property (p_lost) else $error("lost trigger not counted"); // R19

	property p_clear;
		ce && !seq_act |=> pend == 3'd0;
	endproperty
	a_clear: assert property (p_clear) else $error("pending count not cleared"); // R28
endmodule

// File: src/clc_defines.svh
// Register offsets, field positions, reset values and timing counts of the light controller.
`ifndef CLC_DEFINES_SVH
`define CLC_DEFINES_SVH
`define CLC_A_CTRL 8'h00
`define CLC_A_CMD 8'h04
`define CLC_A_CAMW 8'h08
`define CLC_A_STBW 8'h0c
`define CLC_A_STBO 8'h10
`define CLC_A_PFULL 8'h14
`define CLC_A_POVL 8'h18
`define CLC_A_GAP 8'h1c
`define CLC_A_MINP 8'h20
`define CLC_A_SEQT 8'h24
`define CLC_A_STAT 8'h28
`define CLC_A_LOST 8'h2c
`define CLC_A_DONE 8'h30
`define CLC_CTRL_W 19
`define CLC_B_GO 0
`define CLC_B_BEG 1
`define CLC_B_END 2
`define CLC_R_CTRL 19'h00000
`define CLC_R_CAMW 24'h000064
`define CLC_R_STBW 24'h000064
`define CLC_R_STBO 24'h000000
`define CLC_R_PFULL 24'h0000c8
`define CLC_R_POVL 24'h000064
`define CLC_R_GAP 24'h00000a
`define CLC_R_MINP 24'h0000c8
`define CLC_R_SEQT 24'h000001
`endif

// File: src/clc_pkg.sv
// Types shared by the camera and light cycle controller.
package clc_pkg;
	typedef enum logic [1:0] {SEQ_WAIT = 2'b00, SEQ_ACTIVE = 2'b01, SEQ_ENDED = 2'b10} clc_seq_t;
	typedef enum logic [1:0] {ORIG_SELF = 2'b00, ORIG_CMD = 2'b01, ORIG_EVENT = 2'b10} clc_orig_t;
	typedef enum logic [1:0] {BEG_IMM = 2'b00, BEG_CMD = 2'b01, BEG_EVENT = 2'b10} clc_beg_t;
	typedef enum logic [1:0] {END_CMD = 2'b00, END_LEN = 2'b01, END_EVENT = 2'b10} clc_end_t;
	typedef struct packed {
		logic [2:0] esel;
		logic [2:0] bsel;
		logic [2:0] tsel;
		logic [2:0] limit;
		clc_end_t esrc;
		clc_beg_t bsrc;
		logic overlap;
		clc_orig_t orig;
	} clc_ctrl_t;
	typedef struct packed {
		logic launch;
		logic permit;
		logic strobe;
		logic cam;
	} clc_out_t;
endpackage

// File: dv/clc_light_partner.sv
// Behavioural camera and strobed light model that measures the controller pulses.
`timescale 1ns/100ps
module clc_light_partner
	import clc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire clc_out_t light,
	input wire logic clr,
	input wire logic [31:0] room_delay,
	output logic mem_room,
	output int cam_w,
	output int stb_w,
	output int lead,
	output int gap,
	output int n_cam,
	output int n_stb,
	output int n_perm,
	output int n_lau
);
	int t = 0;
	int t_cam = 0;
	int t_stb = 0;
	int t_lau = 0;
	int room_cnt = 0;
	clc_out_t q = '0;
	logic rc;
	logic rs;
	assign rc = light.cam && !q.cam;
	assign rs = light.strobe && !q.strobe;
	// Memory stays full for a while after each launch.
	assign mem_room = (room_cnt == 0);
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			room_cnt <= 0;
		end else if (light.launch) begin
			room_cnt <= room_delay;
		end else if (room_cnt > 0) begin
			room_cnt <= room_cnt - 1;
		end
	end
	always @(posedge clk) begin
		t <= t + 1;
		q <= light;
		if (rc) t_cam <= t;
		if (rs) t_stb <= t;
		if (rc && rs) lead <= 0;
		else if (rc) lead <= t_stb - t;
		else if (rs) lead <= t - t_cam;
		if (!light.cam && q.cam) cam_w <= t - t_cam;
		if (!light.strobe && q.strobe) stb_w <= t - t_stb;
		if (clr) begin
			n_cam <= 0;
			n_stb <= 0;
			n_perm <= 0;
			n_lau <= 0;
			gap <= 1000000;
		end else begin
			n_cam <= n_cam + int'(rc);
			n_stb <= n_stb + int'(rs);
			n_perm <= n_perm + int'(light.permit);
			if (light.launch) begin
				n_lau <= n_lau + 1;
				t_lau <= t;
				if (n_lau > 0 && t - t_lau < gap) gap <= t - t_lau;
			end
		end
	end
endmodule

// File: dv/tb_clc_camera_light_controller.sv
// Self-checking testbench for the camera and light cycle controller.
`timescale 1ns/100ps
`include "clc_defines.svh"
module tb_clc_camera_light_controller
	import clc_pkg::*;
;
	logic clk = 1'b0;
	logic rst_b;
	logic ce;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	logic [31:0] rdata;
	logic [7:0] tool_events;
	logic mem_room;
	clc_out_t light;
	logic clr;
	int room_delay;
	int cam_w, stb_w, lead, gap, n_cam, n_stb, n_perm, n_lau;
	int err_total = 0;
	int check_count = 0;
	int cyc = 0;
	logic [31:0] d;
	logic [7:0] ra [9] = '{`CLC_A_CTRL, `CLC_A_CAMW, `CLC_A_STBW, `CLC_A_STBO, `CLC_A_PFULL,
		`CLC_A_POVL, `CLC_A_GAP, `CLC_A_MINP, `CLC_A_SEQT};
	logic [31:0] rv [9] = '{32'(`CLC_R_CTRL), 32'(`CLC_R_CAMW), 32'(`CLC_R_STBW), 32'(`CLC_R_STBO),
		32'(`CLC_R_PFULL), 32'(`CLC_R_POVL), 32'(`CLC_R_GAP), 32'(`CLC_R_MINP), 32'(`CLC_R_SEQT)};

	always #5 clk = ~clk;

	clc_camera_light_controller #(.TW(24)) u_dut (.clk(clk), .rst_b(rst_b), .ce(ce), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .tool_events(tool_events),
		.mem_room(mem_room), .light(light));

	clc_light_partner u_dev (.clk(clk), .rst_b(rst_b), .light(light), .clr(clr),
		.room_delay(room_delay), .mem_room(mem_room), .cam_w(cam_w), .stb_w(stb_w), .lead(lead),
		.gap(gap), .n_cam(n_cam), .n_stb(n_stb), .n_perm(n_perm), .n_lau(n_lau));

	task automatic conclude;
		$display("Checks %0d, errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
		@(posedge clk);
	endtask

	task automatic ev(input int b);
		tool_events <= 8'(1 << b);
		@(posedge clk);
		tool_events <= 8'h00;
		@(posedge clk);
	endtask

	task automatic fresh;
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		wr_reg(`CLC_A_CMD, 32'h00000002);
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			err_total++;
			conclude();
		end
	end

	initial begin
		rst_b = 1'b0;
		ce = 1'b1;
		addr = 8'h00;
		wdata = 32'h00000000;
		wr = 1'b0;
		rd = 1'b0;
		tool_events = 8'h00;
		clr = 1'b1;
		room_delay = 0;
		idle(20);
		rst_b <= 1'b1;
		clr <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 9; i++) begin
			rd_reg(ra[i], d);
			chk(d, rv[i]);
		end
		rd_reg(8'h40, d);
		chk(d, 32'h00000000);
		rd_reg(`CLC_A_STAT, d);
		chk(32'(d[4:3]), 32'h1);
		chk(n_lau, 1);
		wr_reg(`CLC_A_CMD, 32'h00000004);
		idle(300);
		rd_reg(`CLC_A_STAT, d);
		chk(32'(d[4:3]), 32'h2);
		chk(n_lau, 1);
		ce <= 1'b0;
		wr_reg(`CLC_A_CAMW, 32'h7);
		ce <= 1'b1;
		rd_reg(`CLC_A_CAMW, d);
		chk(d, 32'(`CLC_R_CAMW));
		wr_reg(`CLC_A_CAMW, 32'h3);
		wr_reg(`CLC_A_STBW, 32'h5);
		wr_reg(`CLC_A_STBO, 32'h2);
		wr_reg(`CLC_A_PFULL, 32'ha);
		wr_reg(`CLC_A_MINP, 32'h14);
		fresh();
		idle(105);
		wr_reg(`CLC_A_CMD, 32'h00000004);
		idle(60);
		chk(cam_w, 3);
		chk(stb_w, 5);
		chk(lead, 2);
		chk(32'(gap >= 20), 1);
		chk(32'(n_lau >= 4), 1);
		chk(n_cam, n_lau);
		chk(n_stb, n_lau);
		chk(n_perm, n_lau);
		wr_reg(`CLC_A_CTRL, 32'h00000004);
		wr_reg(`CLC_A_POVL, 32'h4);
		wr_reg(`CLC_A_MINP, 32'h5);
		for (int g = 2; g < 30; g += 18) begin
			wr_reg(`CLC_A_GAP, 32'(g));
			fresh();
			idle(80);
			wr_reg(`CLC_A_CMD, 32'h00000004);
			idle(30);
			chk(32'(gap >= 3 + g), 1);
			chk(32'(g > 2 || gap <= 10), 1);
			chk(n_perm, n_lau);
		end
		wr_reg(`CLC_A_STBO, 32'h00fffffd);
		room_delay <= 40;
		fresh();
		idle(130);
		wr_reg(`CLC_A_CMD, 32'h00000004);
		idle(60);
		chk(lead, 32'hfffffffd);
		chk(cam_w, 3);
		chk(32'(gap >= 40), 1);
		room_delay <= 0;
		wr_reg(`CLC_A_CTRL, 32'h00000020);
		wr_reg(`CLC_A_SEQT, 32'h3);
		fresh();
		idle(5);
		wr_reg(`CLC_A_SEQT, 32'h5);
		idle(150);
		chk(n_lau, 3);
		rd_reg(`CLC_A_DONE, d);
		chk(d, 32'h3);
		rd_reg(`CLC_A_STAT, d);
		chk(32'(d[4:3]), 32'h2);
		wr_reg(`CLC_A_CTRL, 32'h00000101);
		wr_reg(`CLC_A_MINP, 32'h3c);
		fresh();
		idle(5);
		repeat (4) wr_reg(`CLC_A_CMD, 32'h00000001);
		rd_reg(`CLC_A_STAT, d);
		chk(32'(d[2:0]), 32'h2);
		rd_reg(`CLC_A_LOST, d);
		chk(d, 32'h1);
		chk(n_lau, 1);
		idle(200);
		chk(n_lau, 3);
		repeat (3) wr_reg(`CLC_A_CMD, 32'h00000001);
		wr_reg(`CLC_A_CMD, 32'h00000004);
		idle(150);
		chk(n_lau, 4);
		rd_reg(`CLC_A_STAT, d);
		chk(32'(d[2:0]), 32'h0);
		for (int i = 0; i < 8; i++) begin
			wr_reg(`CLC_A_CTRL, 32'h00000002 | 32'(i << 10));
			fresh();
			ev((i + 1) % 8);
			idle(10);
			chk(n_lau, 0);
			ev(i);
			idle(30);
			chk(n_lau, 1);
			wr_reg(`CLC_A_CMD, 32'h00000004);
			idle(40);
		end
		conclude();
	end
endmodule
